// ==== pkg/stwb_pkg.sv ====
// constants and carrier types for the transmit write-port buffer
package stwb_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int PORT_W = 8;
  localparam int PART_W = 3;
  localparam int NUM_PART = 8;
  localparam int WORD_IDX_W = 2;
  localparam int LINE_IDX_W = 2;
  localparam int PTR_W = 3;
  localparam int WORDS_PER_LINE = 4;
  localparam int LINES_PER_PART = 4;
  localparam int LINE_W = DATA_W * WORDS_PER_LINE;
  localparam int MEM_WORDS = NUM_PART * LINES_PER_PART * WORDS_PER_LINE;
  localparam int MEM_LINES = NUM_PART * LINES_PER_PART;

  // ****************************************************************
  // fill levels, reset values and encodings
  // ****************************************************************
  localparam logic [PTR_W-1:0] FILL_MAX = 3'h4;
  localparam logic [PTR_W-1:0] FULL_THRESHOLD = 3'h3;
  localparam logic [PTR_W-1:0] PTR_RST = 3'h0;
  localparam logic [WORD_IDX_W-1:0] WORD_LAST = 2'h3;
  localparam logic [WORD_IDX_W-1:0] WORD_RST = 2'h0;
  localparam logic [BE_W-1:0] BE_NONE = 4'h0;
  localparam logic [PART_W-1:0] PART_RST = 3'h0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0] be;
    logic sop;
    logic eop;
    logic err;
    logic [PORT_W-1:0] port;
  } stwb_word_type;

  typedef struct packed {
    logic [BE_W-1:0] last_be;
    logic [PTR_W-1:0] nwords;
    logic sop;
    logic eop;
    logic err;
    logic [PORT_W-1:0] port;
  } stwb_meta_type;

  typedef struct packed {
    logic [LINE_W-1:0] data;
    stwb_meta_type meta;
    logic [PART_W-1:0] partition;
  } stwb_line_type;

  typedef enum logic [0:0] {
    ST_POLL,
    ST_HALT
  } stwb_sched_type;

endpackage

// ==== rtl/stwb_tx_write_buffer.sv ====
// transmit write-port buffer: fpga-side line writer, partition fifos and poll scheduler
`timescale 1ns/1ps
module stwb_tx_write_buffer (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_tx_wr_clock,
  input wire logic i_tx_wr_enable,
  input wire logic [stwb_pkg::DATA_W-1:0] i_tx_wr_data_word,
  input wire logic [stwb_pkg::BE_W-1:0] i_tx_wr_byte_enables,
  input wire logic i_tx_wr_start_of_packet,
  input wire logic i_tx_wr_end_of_packet,
  input wire logic i_tx_wr_packet_error,
  input wire logic [stwb_pkg::PORT_W-1:0] i_tx_wr_port_number,
  input wire logic [stwb_pkg::PART_W-1:0] i_tx_wr_partition_select,
  input wire logic i_tx_wr_line_terminate,
  input wire logic i_tx_buffer_poll_disable,
  output logic o_tx_partition_full,
  output logic o_line_valid,
  input wire logic i_line_ready,
  output stwb_pkg::stwb_line_type o_line,
  output logic o_send_idle
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [stwb_pkg::PTR_W-1:0] bin2gray(input logic [stwb_pkg::PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [stwb_pkg::PTR_W-1:0] gray2bin(input logic [stwb_pkg::PTR_W-1:0] g);
    logic [stwb_pkg::PTR_W-1:0] b;
    b[stwb_pkg::PTR_W-1] = g[stwb_pkg::PTR_W-1];
    for (int i = stwb_pkg::PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  // lines held, from two line pointers carrying a wrap bit
  function automatic logic [stwb_pkg::PTR_W-1:0] ptr_fill(input logic [stwb_pkg::PTR_W-1:0] wp,
                                                          input logic [stwb_pkg::PTR_W-1:0] rp);
    ptr_fill = wp - rp;
  endfunction

  // ****************************************************************
  // storage, written on the write clock, read on the core clock
  // ****************************************************************
  logic [stwb_pkg::DATA_W-1:0] word_mem [0:stwb_pkg::MEM_WORDS-1];
  stwb_pkg::stwb_meta_type meta_mem [0:stwb_pkg::MEM_LINES-1];

  // ****************************************************************
  // write clock domain
  // ****************************************************************
  logic wr_rst_meta;
  logic wr_rst_n;
  logic [stwb_pkg::PTR_W-1:0] wr_bin [0:stwb_pkg::NUM_PART-1];
  logic [stwb_pkg::PTR_W-1:0] wr_gray [0:stwb_pkg::NUM_PART-1];
  logic [stwb_pkg::WORD_IDX_W-1:0] word_cnt [0:stwb_pkg::NUM_PART-1];
  logic [stwb_pkg::PTR_W-1:0] rd_gray_meta [0:stwb_pkg::NUM_PART-1];
  logic [stwb_pkg::PTR_W-1:0] rd_gray_wsync [0:stwb_pkg::NUM_PART-1];
  logic [stwb_pkg::PTR_W-1:0] rd_gray [0:stwb_pkg::NUM_PART-1];
  stwb_pkg::stwb_word_type wr_word;
  stwb_pkg::stwb_meta_type cur_meta;
  stwb_pkg::stwb_meta_type next_meta;
  logic [stwb_pkg::PART_W-1:0] sel;
  logic [stwb_pkg::PTR_W-1:0] sel_fill;
  logic [stwb_pkg::LINE_IDX_W-1:0] sel_line;
  logic sel_space;
  logic wr_take;
  logic wr_commit;

  // reset release retimed onto the write clock; assertion stays asynchronous
  always_ff @(posedge i_tx_wr_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_rst_meta <= 1'b0;
      wr_rst_n <= 1'b0;
    end else begin
      wr_rst_meta <= 1'b1;
      wr_rst_n <= wr_rst_meta;
    end
  end

  // read pointers brought over from the core clock, two flops each
  always_ff @(posedge i_tx_wr_clock or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      for (int p = 0; p < stwb_pkg::NUM_PART; p++) begin
        rd_gray_meta[p] <= stwb_pkg::PTR_RST;
        rd_gray_wsync[p] <= stwb_pkg::PTR_RST;
      end
    end else begin
      for (int p = 0; p < stwb_pkg::NUM_PART; p++) begin
        rd_gray_meta[p] <= rd_gray[p];
        rd_gray_wsync[p] <= rd_gray_meta[p];
      end
    end
  end

  // the write inputs are synchronous to the write clock, no retiming
  always_comb begin
    wr_word.data = i_tx_wr_data_word;
    wr_word.be = i_tx_wr_byte_enables;
    wr_word.sop = i_tx_wr_start_of_packet;
    wr_word.eop = i_tx_wr_end_of_packet;
    wr_word.err = i_tx_wr_packet_error;
    wr_word.port = i_tx_wr_port_number;
  end

  assign sel = i_tx_wr_partition_select;
  assign sel_fill = ptr_fill(wr_bin[sel], gray2bin(rd_gray_wsync[sel]));
  assign sel_line = wr_bin[sel][stwb_pkg::LINE_IDX_W-1:0];
  // a full partition drops the word: overrun protection, not flow control
  assign sel_space = (sel_fill != stwb_pkg::FILL_MAX);
  // word lands only with enable high and at least one byte lane set
  assign wr_take = i_tx_wr_enable && (wr_word.be != stwb_pkg::BE_NONE) && sel_space;
  // line closes on the fourth word, on end-of-packet, or on terminate over a partial line
  assign wr_commit = sel_space &&
                     ((wr_take && (wr_word.eop || word_cnt[sel] == stwb_pkg::WORD_LAST)) ||
                      (i_tx_wr_line_terminate && (wr_take || word_cnt[sel] != stwb_pkg::WORD_RST)));

  assign cur_meta = meta_mem[{sel, sel_line}];

  // start and end marks gather across the words of one line, error only from the end-of-packet word; port and last byte enables follow the newest word
  always_comb begin
    next_meta = cur_meta;
    next_meta.nwords = {1'b0, word_cnt[sel]} + 3'h1;
    next_meta.last_be = wr_word.be;
    next_meta.port = wr_word.port;
    if (word_cnt[sel] == stwb_pkg::WORD_RST) begin
      next_meta.sop = wr_word.sop;
      next_meta.eop = wr_word.eop;
      next_meta.err = wr_word.eop && wr_word.err;
    end else begin
      next_meta.sop = cur_meta.sop | wr_word.sop;
      next_meta.eop = cur_meta.eop | wr_word.eop;
      next_meta.err = cur_meta.err | (wr_word.eop && wr_word.err);
    end
  end

  // storage write port; no reset, contents are qualified by pointers
  always_ff @(posedge i_tx_wr_clock) begin
    if (wr_take) begin
      word_mem[{sel, sel_line, word_cnt[sel]}] <= wr_word.data;
      meta_mem[{sel, sel_line}] <= next_meta;
    end
  end

  // per-partition word position and line pointer, still accepted while polling is off
  always_ff @(posedge i_tx_wr_clock or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      for (int p = 0; p < stwb_pkg::NUM_PART; p++) begin
        wr_bin[p] <= stwb_pkg::PTR_RST;
        wr_gray[p] <= stwb_pkg::PTR_RST;
        word_cnt[p] <= stwb_pkg::WORD_RST;
      end
    end else begin
      if (wr_commit) begin
        wr_bin[sel] <= wr_bin[sel] + 3'h1;
        wr_gray[sel] <= bin2gray(wr_bin[sel] + 3'h1);
        word_cnt[sel] <= stwb_pkg::WORD_RST;
      end else if (wr_take) begin
        word_cnt[sel] <= word_cnt[sel] + 2'h1;
      end
    end
  end

  // full status of the addressed partition, one write clock behind the select
  always_ff @(posedge i_tx_wr_clock or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      o_tx_partition_full <= 1'b0;
    end else begin
      o_tx_partition_full <= (sel_fill >= stwb_pkg::FULL_THRESHOLD);
    end
  end

  // ****************************************************************
  // core clock domain
  // ****************************************************************
  logic dis_meta;
  logic dis_sync;
  logic [stwb_pkg::PTR_W-1:0] wr_gray_meta [0:stwb_pkg::NUM_PART-1];
  logic [stwb_pkg::PTR_W-1:0] wr_gray_csync [0:stwb_pkg::NUM_PART-1];
  logic [stwb_pkg::PTR_W-1:0] rd_bin [0:stwb_pkg::NUM_PART-1];
  logic [stwb_pkg::NUM_PART-1:0] nonempty;
  logic [stwb_pkg::PART_W-1:0] last_part;
  logic [stwb_pkg::PART_W-1:0] pick;
  logic found;
  logic issue;
  logic buf_in_ready;
  stwb_pkg::stwb_sched_type state;
  stwb_pkg::stwb_sched_type next_state;
  stwb_pkg::stwb_line_type pick_line;

  // poll disable and write pointers enter the core clock through two flops
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dis_meta <= 1'b0;
      dis_sync <= 1'b0;
      for (int p = 0; p < stwb_pkg::NUM_PART; p++) begin
        wr_gray_meta[p] <= stwb_pkg::PTR_RST;
        wr_gray_csync[p] <= stwb_pkg::PTR_RST;
      end
    end else if (i_ce) begin
      dis_meta <= i_tx_buffer_poll_disable;
      dis_sync <= dis_meta;
      for (int p = 0; p < stwb_pkg::NUM_PART; p++) begin
        wr_gray_meta[p] <= wr_gray[p];
        wr_gray_csync[p] <= wr_gray_meta[p];
      end
    end
  end

  // a partition is pollable once a closed line has crossed over
  always_comb begin
    for (int p = 0; p < stwb_pkg::NUM_PART; p++) begin
      nonempty[p] = (wr_gray_csync[p] != rd_gray[p]);
    end
  end

  // round robin from the partition after the last one served
  always_comb begin
    logic [stwb_pkg::PART_W-1:0] idx;
    idx = stwb_pkg::PART_RST;
    found = 1'b0;
    pick = last_part;
    for (int k = 1; k <= stwb_pkg::NUM_PART; k++) begin
      idx = 3'(last_part + k[2:0]);
      if (!found && nonempty[idx]) begin
        found = 1'b1;
        pick = idx;
      end
    end
  end

  // scheduler halts while polling is disabled and resumes only after release
  always_comb begin
    next_state = state;
    case (state)
      stwb_pkg::ST_POLL: begin
        if (dis_sync) begin
          next_state = stwb_pkg::ST_HALT;
        end
      end
      stwb_pkg::ST_HALT: begin
        if (!dis_sync) begin
          next_state = stwb_pkg::ST_POLL;
        end
      end
      default: begin
        next_state = stwb_pkg::ST_HALT;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= stwb_pkg::ST_POLL;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // gated by the synchronised disable too, so the halt edge takes effect at once
  assign issue = (state == stwb_pkg::ST_POLL) && !dis_sync && found && buf_in_ready;

  // line read straight from storage; its pointer crossing guarantees it is settled
  always_comb begin
    pick_line.partition = pick;
    pick_line.meta = meta_mem[{pick, rd_bin[pick][stwb_pkg::LINE_IDX_W-1:0]}];
    for (int w = 0; w < stwb_pkg::WORDS_PER_LINE; w++) begin
      pick_line.data[w*stwb_pkg::DATA_W +: stwb_pkg::DATA_W] =
        word_mem[{pick, rd_bin[pick][stwb_pkg::LINE_IDX_W-1:0], w[1:0]}];
    end
  end

  // read pointers and round robin position
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_part <= stwb_pkg::PART_RST;
      for (int p = 0; p < stwb_pkg::NUM_PART; p++) begin
        rd_bin[p] <= stwb_pkg::PTR_RST;
        rd_gray[p] <= stwb_pkg::PTR_RST;
      end
    end else if (i_ce && issue) begin
      last_part <= pick;
      rd_bin[pick] <= rd_bin[pick] + 3'h1;
      rd_gray[pick] <= bin2gray(rd_bin[pick] + 3'h1);
    end
  end

  // ****************************************************************
  // two-entry output buffer
  // ****************************************************************
  stwb_pkg::stwb_line_type buf_q [0:1];
  logic buf_wr_idx;
  logic buf_rd_idx;
  logic [1:0] buf_count;
  logic buf_pop;

  // a stall downstream fills the buffer and then stops the scheduler
  assign buf_in_ready = (buf_count != 2'h2);
  assign o_line_valid = (buf_count != 2'h0);
  assign buf_pop = o_line_valid && i_line_ready;
  assign o_line = buf_q[buf_rd_idx];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      buf_wr_idx <= 1'b0;
      buf_rd_idx <= 1'b0;
      buf_count <= 2'h0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (i_ce) begin
      if (issue) begin
        buf_q[buf_wr_idx] <= pick_line;
        buf_wr_idx <= ~buf_wr_idx;
      end
      if (buf_pop) begin
        buf_rd_idx <= ~buf_rd_idx;
      end
      buf_count <= buf_count + {1'b0, issue} - {1'b0, buf_pop};
    end
  end

  // idle words go out while disabled or with nothing queued
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_send_idle <= 1'b1;
    end else if (i_ce) begin
      o_send_idle <= dis_sync || (state == stwb_pkg::ST_HALT) || !(found || o_line_valid);
    end
  end

endmodule

// ==== tb/stwb_chk.sv ====
// assertion checker for the transmit write-port buffer
`timescale 1ns/1ps
module stwb_chk (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_tx_wr_clock,
  input wire logic i_tx_wr_enable,
  input wire logic i_tx_wr_line_terminate,
  input wire logic [stwb_pkg::PART_W-1:0] i_tx_wr_partition_select,
  input wire logic i_tx_buffer_poll_disable,
  input wire logic i_line_ready,
  input wire logic o_tx_partition_full,
  input wire logic o_line_valid,
  input wire stwb_pkg::stwb_line_type o_line,
  input wire logic o_send_idle
);
  // ****
  // line output and scheduler
  // ****
  sequence s_stall;
    o_line_valid && !(i_line_ready && i_ce);
  endsequence
  sequence s_dis_held;
    i_tx_buffer_poll_disable [*5];
  endsequence
  chk_valid_hold: assert property (@(posedge i_clk) disable iff (!i_resetn) s_stall |=> o_line_valid)
    else $error("line valid dropped while stalled");
  chk_line_stable: assert property (@(posedge i_clk) disable iff (!i_resetn) s_stall |=> $stable(o_line))
    else $error("held line changed while stalled");
  chk_pop_fall: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(o_line_valid) |-> $past(i_line_ready && i_ce))
    else $error("line valid fell without a pop");
  chk_nwords_range: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_line_valid |-> o_line.meta.nwords inside {[3'h1:3'h4]})
    else $error("line word count out of range");
  chk_err_eop: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_line_valid && o_line.meta.err |-> o_line.meta.eop)
    else $error("error mark without end of packet");
  chk_idle_disable: assert property (@(posedge i_clk) disable iff (!i_resetn) s_dis_held |=> o_send_idle)
    else $error("no idle while polling disabled");
  chk_issue_enabled: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(o_line_valid) |-> !$past(i_tx_buffer_poll_disable, 3))
    else $error("line issued while polling disabled");
  // ****
  // write side full status
  // ****
  chk_full_cause: assert property (@(posedge i_tx_wr_clock) disable iff (!i_resetn)
    $rose(o_tx_partition_full) |-> $past(i_tx_wr_enable) || $past(i_tx_wr_enable, 2)
    || $past(i_tx_wr_line_terminate, 2) || $past(i_tx_wr_partition_select) != $past(i_tx_wr_partition_select, 2))
    else $error("full rose with no write or select change");
endmodule
bind stwb_tx_write_buffer stwb_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce),
  .i_tx_wr_clock(i_tx_wr_clock), .i_tx_wr_enable(i_tx_wr_enable), .i_tx_wr_line_terminate(i_tx_wr_line_terminate),
  .i_tx_wr_partition_select(i_tx_wr_partition_select), .i_tx_buffer_poll_disable(i_tx_buffer_poll_disable),
  .i_line_ready(i_line_ready), .o_tx_partition_full(o_tx_partition_full), .o_line_valid(o_line_valid),
  .o_line(o_line), .o_send_idle(o_send_idle));

// ==== tb/stwb_writer_model.sv ====
// behavioural fpga-side writer feeding the transmit write port
`timescale 1ns/1ps
module stwb_writer_model (
  input wire logic i_clk,
  output logic o_we,
  output logic [stwb_pkg::DATA_W-1:0] o_data,
  output logic [stwb_pkg::BE_W-1:0] o_be,
  output logic o_sop,
  output logic o_eop,
  output logic o_err,
  output logic [stwb_pkg::PORT_W-1:0] o_port,
  output logic [stwb_pkg::PART_W-1:0] o_sel,
  output logic o_term
);
  // ****
  // writer tasks
  // ****
  initial begin
    o_we = 1'b0;
    o_data = 32'h0;
    o_be = 4'hf;
    o_sop = 1'b0;
    o_eop = 1'b0;
    o_err = 1'b0;
    o_port = 8'h0;
    o_sel = 3'h0;
    o_term = 1'b0;
  end
  // one word per edge, qualifiers exactly as commanded
  task automatic put(input logic [31:0] d, input logic [3:0] b, input logic [2:0] q, input logic [7:0] p,
    input logic s, input logic e, input logic r, input logic w);
    @(posedge i_clk);
    o_we <= w;
    o_data <= d;
    o_be <= b;
    o_sel <= q;
    o_port <= p;
    o_sop <= s;
    o_eop <= e;
    o_err <= r;
    o_term <= 1'b0;
  endtask
  // released data is inverted so a stale word never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_we <= 1'b0;
      o_term <= 1'b0;
      o_data <= ~o_data;
    end
  endtask
  task automatic sel(input logic [2:0] q);
    @(posedge i_clk);
    o_we <= 1'b0;
    o_sel <= q;
  endtask
  task automatic term(input logic [2:0] q);
    @(posedge i_clk);
    o_we <= 1'b0;
    o_sel <= q;
    o_term <= 1'b1;
  endtask
endmodule

// ==== tb/stwb_tx_write_buffer_tb_top.sv ====
// self-checking bench for the transmit write-port buffer
`timescale 1ns/1ps
module stwb_tx_write_buffer_tb_top;
  // ****
  // harness
  // ****
  logic clk, wclk, resetn, ce, dis, ready, we, sop, eop, err, term, full, valid, idle;
  logic [31:0] data;
  logic [3:0] be;
  logic [7:0] port;
  logic [2:0] sel;
  stwb_pkg::stwb_line_type line;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  stwb_writer_model wr (.i_clk(wclk), .o_we(we), .o_data(data), .o_be(be), .o_sop(sop), .o_eop(eop),
    .o_err(err), .o_port(port), .o_sel(sel), .o_term(term));
  stwb_tx_write_buffer dut (.i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_tx_wr_clock(wclk),
    .i_tx_wr_enable(we), .i_tx_wr_data_word(data), .i_tx_wr_byte_enables(be),
    .i_tx_wr_start_of_packet(sop), .i_tx_wr_end_of_packet(eop), .i_tx_wr_packet_error(err),
    .i_tx_wr_port_number(port), .i_tx_wr_partition_select(sel), .i_tx_wr_line_terminate(term),
    .i_tx_buffer_poll_disable(dis), .o_tx_partition_full(full), .o_line_valid(valid),
    .i_line_ready(ready), .o_line(line), .o_send_idle(idle));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // write clock offset so its edges never meet the core edges
  initial begin
    wclk = 1'b0;
    #7;
    forever #15 wclk = ~wclk;
  end
  // hang guard, far above the expected couple of hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  // only the words the line really holds are compared
  task automatic cmp_line(input stwb_pkg::stwb_line_type got, input stwb_pkg::stwb_line_type exp);
    logic [127:0] m;
    m = {128{1'b1}} >> (32 * (4 - exp.meta.nwords));
    n_tests++;
    if ((got.data & m) !== (exp.data & m) || got.meta !== exp.meta || got.partition !== exp.partition) begin
      n_fail++;
      $display("[ERR] %0t line got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic stwb_pkg::stwb_line_type mk(input logic [127:0] d, input logic [2:0] nw, input logic [3:0] lb,
    input logic [2:0] q, input logic [7:0] pt, input logic s, input logic e, input logic r);
    return '{data: d, meta: '{last_be: lb, nwords: nw, sop: s, eop: e, err: r, port: pt}, partition: q};
  endfunction
  // receiver stalls until the line is seen, then pops it
  task automatic take(output stwb_pkg::stwb_line_type l);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (valid !== 1'b1 && k < 200);
    cmp_bit(valid, 1'b1);
    cmp_bit(idle, 1'b0);
    l = line;
    @(posedge clk);
    ready <= 1'b1;
    @(posedge clk);
    ready <= 1'b0;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_line();
    stwb_pkg::stwb_line_type l;
    wr.put(32'h1111_0000, 4'hf, 3'h2, 8'h15, 1'b1, 1'b0, 1'b0, 1'b1);
    wr.put(32'hdead_beef, 4'hf, 3'h2, 8'h15, 1'b0, 1'b0, 1'b0, 1'b0);
    wr.put(32'hbad0_bad0, 4'h0, 3'h2, 8'h15, 1'b0, 1'b0, 1'b0, 1'b1);
    wr.put(32'h1111_0001, 4'hf, 3'h2, 8'h15, 1'b0, 1'b0, 1'b0, 1'b1);
    wr.put(32'h1111_0002, 4'hf, 3'h2, 8'h15, 1'b0, 1'b0, 1'b0, 1'b1);
    wr.put(32'h1111_0003, 4'hf, 3'h2, 8'h16, 1'b0, 1'b0, 1'b0, 1'b1);
    wr.idle(1);
    take(l);
    cmp_line(l, mk(128'h1111_0003_1111_0002_1111_0001_1111_0000, 3'h4, 4'hf, 3'h2, 8'h16, 1'b1, 1'b0, 1'b0));
    $display("test line done");
  endtask
  task automatic t_parts();
    stwb_pkg::stwb_line_type l;
    for (int p = 0; p < 8; p++) begin
      wr.put(32'h2000_0000 + p, 4'hf, p[2:0], p[7:0], 1'b1, 1'b0, 1'b0, 1'b1);
      wr.put(32'h2100_0000 + p, 4'hc, p[2:0], p[7:0], 1'b0, 1'b1, p[0], 1'b1);
      wr.idle(1);
      take(l);
      cmp_line(l, mk({64'h0, 32'h2100_0000 + p, 32'h2000_0000 + p}, 3'h2, 4'hc, p[2:0], p[7:0], 1'b1, 1'b1, p[0]));
    end
    $display("test partitions done");
  endtask
  task automatic t_term();
    stwb_pkg::stwb_line_type l;
    wr.term(3'h7);
    wr.put(32'h7777_0000, 4'hf, 3'h7, 8'h77, 1'b1, 1'b0, 1'b0, 1'b1);
    wr.term(3'h7);
    wr.idle(1);
    take(l);
    cmp_line(l, mk(128'h7777_0000, 3'h1, 4'hf, 3'h7, 8'h77, 1'b1, 1'b0, 1'b0));
    $display("test terminate done");
  endtask
  task automatic t_full();
    stwb_pkg::stwb_line_type l;
    @(posedge clk);
    dis <= 1'b1;
    repeat (8) @(posedge clk);
    for (int k = 0; k < 12; k++) begin
      wr.put(32'h3000_0000 + k, 4'hf, 3'h1, 8'h31, k % 4 == 0, 1'b0, 1'b0, 1'b1);
    end
    wr.idle(3);
    #1;
    cmp_bit(full, 1'b1);
    cmp_bit(idle, 1'b1);
    cmp_bit(valid, 1'b0);
    wr.sel(3'h3);
    wr.idle(2);
    #1;
    cmp_bit(full, 1'b0);
    wr.sel(3'h1);
    wr.idle(2);
    #1;
    cmp_bit(full, 1'b1);
    @(posedge clk);
    dis <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      repeat (5) @(posedge clk);
      take(l);
      cmp_line(l, mk({32'h3000_0003 + 4 * k, 32'h3000_0002 + 4 * k, 32'h3000_0001 + 4 * k, 32'h3000_0000 + 4 * k},
        3'h4, 4'hf, 3'h1, 8'h31, 1'b1, 1'b0, 1'b0));
    end
    wr.idle(40);
    #1;
    cmp_bit(full, 1'b0);
    $display("test full done");
  endtask
  // core frozen by its clock enable: nothing crosses or issues until it rises again
  task automatic t_ce();
    stwb_pkg::stwb_line_type l;
    @(posedge clk);
    ce <= 1'b0;
    wr.put(32'h4444_0000, 4'h8, 3'h4, 8'h44, 1'b1, 1'b1, 1'b0, 1'b1);
    wr.idle(1);
    repeat (10) @(posedge clk);
    @(negedge clk);
    cmp_bit(valid, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    take(l);
    cmp_line(l, mk(128'h4444_0000, 3'h1, 4'h8, 3'h4, 8'h44, 1'b1, 1'b1, 1'b0));
    $display("test clock enable done");
  endtask
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    dis = 1'b0;
    ready = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    wr.idle(4);
    t_line();
    t_parts();
    t_term();
    t_full();
    t_ce();
    stop_test();
  end
endmodule
